/* File: rtl/sras_edges.sv */
// Finds the edges of the synchronised select and bus clock and drives the pin interface.
`timescale 1ns/1ns
module sras_edges (
    // System clock and reset.
    input  wire logic      clock,
    input  wire logic      rst_b,
    // Synchronised pin levels.
    input  wire logic      selectSync,
    input  wire logic      busClockSync,
    input  wire logic      serialSync,
    // Levels and edge pulses for the core.
    sras_pins_if.producer  pins
);
    logic selectLast_reg;
    logic busClockLast_reg;

    // Resets to idle levels: select high, bus clock high, so no edge fires out of reset.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            selectLast_reg   <= 1'h1;
            busClockLast_reg <= 1'h1;
        end else begin
            selectLast_reg   <= selectSync;
            busClockLast_reg <= busClockSync;
        end
    end

    assign pins.selectN  = selectSync;
    assign pins.serialIn = serialSync;
    assign pins.selFall  = selectLast_reg & ~selectSync;
    assign pins.selRise  = ~selectLast_reg & selectSync;
    assign pins.clkRise  = ~busClockLast_reg & busClockSync;
    assign pins.clkFall  = busClockLast_reg & ~busClockSync;
endmodule

/* File: rtl/sras_pins_if.sv */
// Sampled host pin levels and their edge pulses, passed from the edge finder to the slave core.
`timescale 1ns/1ns
interface sras_pins_if;
    logic selectN;
    logic serialIn;
    logic selFall;
    logic selRise;
    logic clkRise;
    logic clkFall;

    modport producer (
        output selectN,
        output serialIn,
        output selFall,
        output selRise,
        output clkRise,
        output clkFall
    );

    modport consumer (
        input selectN,
        input serialIn,
        input selFall,
        input selRise,
        input clkRise,
        input clkFall
    );
endinterface

/* File: rtl/sras_pkg.sv */
// Constants and types shared by the serial register access slave.
package sras_pkg;

    // Datagram layout: one address byte and one 32-bit data word, most significant bit first.
    localparam int DATAGRAM_BITS  = 40;
    localparam int STATUS_BITS    = 8;
    localparam int ADDR_BITS      = 7;
    localparam int DATA_BITS      = 32;
    localparam int WRITE_FLAG_POS = 39;
    localparam int ADDR_MSB_POS   = 38;
    localparam int ADDR_LSB_POS   = 32;
    localparam int COUNT_BITS     = 6;

    // Reset values of the held reply word and of the output pins.
    localparam logic [31:0] REPLY_RESET      = 32'h0000_0000;
    localparam logic [6:0]  ADDR_RESET       = 7'h00;
    localparam logic        SERIAL_OUT_RESET = 1'h0;

    // Timing: the bus clock may run at no more than a quarter of the system clock.
    localparam int CLOCK_PERIOD_NS         = 4;
    localparam int BUS_CLOCK_DIVISOR       = 4;
    localparam int BUS_CLOCK_MIN_PERIOD_NS = CLOCK_PERIOD_NS * BUS_CLOCK_DIVISOR;
    localparam int BUS_HALF_MIN_CYCLES     =
        (BUS_CLOCK_MIN_PERIOD_NS / 2 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int GAP_BITS                = 3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_READ
    } sras_state_type;

endpackage

/* File: rtl/sras_slave.sv */
// Serial host port: 40-bit full-duplex datagrams giving access to an internal register file.
`timescale 1ns/1ns

module sras_slave
    import sras_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_BITS,
    parameter int ADDR_WIDTH = ADDR_BITS
) (
    // System clock and reset.
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // Host serial pins.
    input  wire logic                  hostSelectN,
    input  wire logic                  hostBusClock,
    input  wire logic                  hostSerialIn,
    output logic                       hostSerialOut,
    output logic                       hostSerialOutEnN,
    // Event status returned at the head of every datagram.
    input  wire logic [STATUS_BITS-1:0] statusByte,
    output logic                       statusTaken,
    // Internal register file port.
    output logic [ADDR_WIDTH-1:0]      regAddr,
    output logic [DATA_WIDTH-1:0]      regWriteData,
    output logic                       regWriteStrobe,
    output logic                       regReadStrobe,
    input  wire logic [DATA_WIDTH-1:0] regReadData,
    // Frame and link health.
    output logic                       frameBusy,
    output logic                       frameInvalid,
    output logic                       busTooFast
);
    localparam int                    SHIFT_BITS = STATUS_BITS + DATA_WIDTH;
    localparam logic [COUNT_BITS-1:0] FULL_COUNT = COUNT_BITS'(SHIFT_BITS);
    localparam logic [GAP_BITS-1:0]   GAP_LIMIT  = GAP_BITS'(BUS_HALF_MIN_CYCLES - 1);
    localparam logic [GAP_BITS-1:0]   GAP_MAX    = '1;

    logic [2:0]                 syncedPins;
    sras_pins_if                pins ();

    sras_state_type             state_reg;
    sras_state_type             state_next;
    logic [SHIFT_BITS-1:0]      shift_reg;
    logic [COUNT_BITS-1:0]      bitCount_reg;
    logic [DATA_WIDTH-1:0]      reply_reg;
    logic [GAP_BITS-1:0]        gap_reg;
    logic                       frameComplete;
    logic                       writeFlag;
    logic                       commit;
    logic [DATA_WIDTH-1:0]      loadWord;

    // All three host inputs share one synchroniser, so their relative timing is kept.
    sras_sync #(
        .WIDTH   (3)
    ) pinSync (
        .clock   (clock),
        .rst_b   (rst_b),
        .rawIn   ({hostSelectN, hostBusClock, hostSerialIn}),
        .syncOut (syncedPins)
    );

    sras_edges edgeFinder (
        .clock        (clock),
        .rst_b        (rst_b),
        .selectSync   (syncedPins[2]),
        .busClockSync (syncedPins[1]),
        .serialSync   (syncedPins[0]),
        .pins         (pins.producer)
    );

    // A frame counts only when exactly the required number of bits, or more, arrived.
    assign frameComplete = (bitCount_reg == FULL_COUNT);
    assign writeFlag     = shift_reg[WRITE_FLAG_POS];
    assign commit        = (state_reg == ST_FRAME) && pins.selRise && frameComplete;

    // A select that falls in the capture cycle must still return the fresh read value.
    assign loadWord = (state_reg == ST_READ) ? regReadData : reply_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pins.selFall) begin
                    state_next = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (pins.selRise) begin
                    state_next = (frameComplete && !writeFlag) ? ST_READ : ST_IDLE;
                end
            end
            ST_READ: begin
                state_next = pins.selFall ? ST_FRAME : ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // The shifter is loaded with status and reply at select fall, then shifts on each rise.
    // After forty rises it holds the received bits, which then leave again forty clocks later.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
        end else if (pins.selFall) begin
            shift_reg <= {statusByte, loadWord};
        end else if (state_reg == ST_FRAME && pins.clkRise) begin
            shift_reg <= {shift_reg[SHIFT_BITS-2:0], pins.serialIn};
        end
    end

    // Counts rises up to forty and stops there, so longer daisy-chain frames still count.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bitCount_reg <= '0;
        end else if (pins.selFall) begin
            bitCount_reg <= '0;
        end else if (state_reg == ST_FRAME && pins.clkRise && bitCount_reg != FULL_COUNT) begin
            bitCount_reg <= bitCount_reg + COUNT_BITS'(1);
        end
    end

    // The output moves only at select fall and after a falling bus clock, so the host samples it stable.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hostSerialOut <= SERIAL_OUT_RESET;
        end else if (pins.selFall) begin
            hostSerialOut <= statusByte[STATUS_BITS-1];
        end else if (state_reg == ST_FRAME && pins.clkFall) begin
            hostSerialOut <= shift_reg[SHIFT_BITS-1];
        end
    end

    // The output pin is driven only while a frame is open; enable is active low.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hostSerialOutEnN <= 1'h1;
            frameBusy        <= 1'h0;
        end else begin
            hostSerialOutEnN <= pins.selectN;
            frameBusy        <= ~pins.selectN;
        end
    end

    // Command decode at select rise: address and data are taken from the last forty bits.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            regAddr        <= ADDR_RESET;
            regWriteData   <= REPLY_RESET;
            regWriteStrobe <= 1'h0;
            regReadStrobe  <= 1'h0;
        end else begin
            regWriteStrobe <= commit && writeFlag;
            regReadStrobe  <= commit && !writeFlag;
            if (commit) begin
                regAddr <= shift_reg[ADDR_MSB_POS:ADDR_LSB_POS];
            end
            // Read frames leave the write data port alone, since their data bits are dummies.
            if (commit && writeFlag) begin
                regWriteData <= shift_reg[DATA_WIDTH-1:0];
            end
        end
    end

    // The reply word for the next datagram: write data echoed, or the value just read.
    // Register values are passed through untouched, so alignment and sign stay as stored.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reply_reg <= REPLY_RESET;
        end else if (commit && writeFlag) begin
            reply_reg <= shift_reg[DATA_WIDTH-1:0];
        end else if (state_reg == ST_READ) begin
            reply_reg <= regReadData;
        end
    end

    // One-cycle reports: status sent out, and a frame dropped for being short.
    // The status byte goes out even on a short frame, so a status poll needs eight clocks.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            statusTaken  <= 1'h0;
            frameInvalid <= 1'h0;
        end else begin
            statusTaken  <= pins.selFall;
            frameInvalid <= (state_reg == ST_FRAME) && pins.selRise && !frameComplete;
        end
    end

    // Half periods shorter than the sampling allows can lose bus clock edges; flag them while select is low.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap_reg    <= GAP_MAX;
            busTooFast <= 1'h0;
        end else if (pins.clkRise || pins.clkFall) begin
            gap_reg    <= '0;
            busTooFast <= !pins.selectN && (gap_reg < GAP_LIMIT);
        end else begin
            if (gap_reg != GAP_MAX) begin
                gap_reg <= gap_reg + GAP_BITS'(1);
            end
            busTooFast <= 1'h0;
        end
    end

endmodule

/* File: rtl/sras_sync.sv */
// Two-flop synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ns
module sras_sync #(
    parameter int WIDTH = 3
) (
    // System clock and reset.
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Raw pins and their synchronised copies.
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second, so a metastable level never reaches logic.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= '1;
            stage2_reg <= '1;
        end else begin
            stage1_reg <= rawIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule

/* File: test/sras_host_model.sv */
// Behavioural host master that frames datagrams on the serial pins.
`timescale 1ns/1ns
module sras_host_model (
    // System clock, used only to keep pin edges off its sampling edge.
    input wire logic clock,
    // Host serial pins.
    output logic     hostSelectN,
    output logic     hostBusClock,
    output logic     hostSerialIn,
    input wire logic hostSerialOut,
    input wire logic hostSerialOutEnN
);
    localparam int HALF_NS = 80;

    initial begin
        hostSelectN = 1'h1;
        hostBusClock = 1'h1;
        hostSerialIn = 1'h0;
    end

    // Sends the low n bits of tx, most significant first, and gathers the reply.
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        @(posedge clock);
        #1 hostSelectN = 1'h0;
        #(HALF_NS);
        for (int i = n - 1; i >= 0; i--) begin
            hostBusClock = 1'h0;
            hostSerialIn = tx[i];
            #(HALF_NS);
            hostBusClock = 1'h1;
            // An undriven line reads as the inverse of its last level, so a missing drive shows.
            rx = {rx[46:0], hostSerialOutEnN ? ~hostSerialOut : hostSerialOut};
            #(HALF_NS);
        end
        hostSelectN = 1'h1;
        // A released data line must not keep showing its last bit.
        hostSerialIn = ~hostSerialIn;
        #(2 * HALF_NS);
    endtask

    // Pulses the bus clock low for one system clock inside a frame, faster than allowed.
    task automatic glitch();
        @(posedge clock);
        #1 hostSelectN = 1'h0;
        #(HALF_NS);
        hostBusClock = 1'h0;
        #4;
        hostBusClock = 1'h1;
        #(HALF_NS);
        hostSelectN = 1'h1;
        #(2 * HALF_NS);
    endtask
endmodule

/* File: test/sras_slave_assertions.sv */
// Port-level checker for the serial register access slave.
`timescale 1ns/1ns
module sras_slave_chk
    import sras_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_BITS,
    parameter int ADDR_WIDTH = ADDR_BITS
) (
    // System clock and reset.
    input wire logic                   clock,
    input wire logic                   rst_b,
    // Host serial pins.
    input wire logic                   hostSelectN,
    input wire logic                   hostBusClock,
    input wire logic                   hostSerialIn,
    input wire logic                   hostSerialOut,
    input wire logic                   hostSerialOutEnN,
    // Status and register port.
    input wire logic [STATUS_BITS-1:0] statusByte,
    input wire logic                   statusTaken,
    input wire logic [ADDR_WIDTH-1:0]  regAddr,
    input wire logic [DATA_WIDTH-1:0]  regWriteData,
    input wire logic                   regWriteStrobe,
    input wire logic                   regReadStrobe,
    input wire logic [DATA_WIDTH-1:0]  regReadData,
    // Frame health.
    input wire logic                   frameBusy,
    input wire logic                   frameInvalid,
    input wire logic                   busTooFast
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // The enable follows the select pin three clocks late, through the synchroniser.
    chk_enable_tracks_busy: assert property
        ((hostSerialOutEnN == $past(hostSelectN, 3)) && (hostSerialOutEnN == !frameBusy))
        else $error("output enable disagrees with select or frame busy");
    chk_select_starts: assert property ($fell(hostSelectN) |-> ##[2:5] $rose(frameBusy))
        else $error("frame did not start after select fall");
    chk_select_ends: assert property ($rose(hostSelectN) |-> ##[2:5] $fell(frameBusy))
        else $error("frame did not end after select rise");
    chk_status_loaded: assert property ($rose(frameBusy) |-> statusTaken)
        else $error("status not taken at frame start");
    chk_outcome_at_end: assert property
        ((regWriteStrobe || regReadStrobe || frameInvalid) |-> $fell(frameBusy))
        else $error("frame outcome away from frame end");
    chk_one_outcome: assert property
        ($onehot0({regWriteStrobe, regReadStrobe, frameInvalid}))
        else $error("more than one frame outcome at once");
    chk_addr_held: assert property
        ($changed(regAddr) |-> (regWriteStrobe || regReadStrobe))
        else $error("address moved without a command");
    chk_wdata_held: assert property ($changed(regWriteData) |-> regWriteStrobe)
        else $error("write data moved without a write");
    chk_single_strobe: assert property
        ((regWriteStrobe || regReadStrobe) |=> !(regWriteStrobe || regReadStrobe) [*8])
        else $error("strobe repeated within a frame");
    chk_fast_in_frame: assert property (busTooFast |-> frameBusy)
        else $error("bus clock speed flagged outside a frame");
endmodule

bind sras_slave sras_slave_chk #(.DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH))
    sras_slave_chk_inst (.*);

/* File: test/tb.sv */
// Self-checking bench for the serial register access slave.
`timescale 1ns/1ns
module tb;
    import sras_pkg::*;
    logic        clock, rst_b, hostSelectN, hostBusClock, hostSerialIn;
    logic        hostSerialOut, hostSerialOutEnN, statusTaken, regWriteStrobe;
    logic        regReadStrobe, frameBusy, frameInvalid, busTooFast;
    logic [7:0]  statusByte;
    logic [6:0]  regAddr;
    logic [31:0] regWriteData, regReadData;
    logic [47:0] rx;
    int          err_total = 0, n_checks = 0, wrCount = 0, rdCount = 0, badCount = 0;
    int          fastCount = 0;

    sras_slave sras_slave_inst (.clock, .rst_b, .hostSelectN, .hostBusClock, .hostSerialIn,
        .hostSerialOut, .hostSerialOutEnN, .statusByte, .statusTaken, .regAddr,
        .regWriteData, .regWriteStrobe, .regReadStrobe, .regReadData, .frameBusy,
        .frameInvalid, .busTooFast);
    sras_host_model sras_host_model_inst (.clock, .hostSelectN, .hostBusClock,
        .hostSerialIn, .hostSerialOut, .hostSerialOutEnN);

    always @(posedge clock) begin
        if (regWriteStrobe === 1'h1) wrCount++;
        if (regReadStrobe === 1'h1) rdCount++;
        if (frameInvalid === 1'h1) badCount++;
        if (busTooFast === 1'h1) fastCount++;
    end

    task automatic check_val(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_num(input string what, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            err_total++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic frame(input logic [47:0] tx, input int n);
        sras_host_model_inst.xfer(tx, n, rx);
    endtask

    task automatic test_pipeline();
        @(posedge clock);
        statusByte <= 8'hA5;
        regReadData <= 32'h1234_5678;
        frame(48'h21_0000_0000, 40);
        check_val("first reply", 48'hA5_0000_0000, rx);
        check_val("read addr", 48'h21, regAddr);
        frame(48'h21_FFFF_FFFF, 40);
        check_val("read reply", 48'hA5_1234_5678, rx);
        check_val("dummy data", 48'h0, regWriteData);
        frame(48'hA2_00AB_CDEF, 40);
        check_val("reply after read", 48'hA5_1234_5678, rx);
        check_val("write addr", 48'h22, regAddr);
        check_val("write data", 48'h00AB_CDEF, regWriteData);
        frame(48'hA2_0012_3456, 40);
        check_val("echo", 48'hA5_00AB_CDEF, rx);
        check_num("writes", 2, wrCount);
        check_num("reads", 2, rdCount);
        $display("test_pipeline done");
    endtask

    task automatic test_short();
        @(posedge clock);
        statusByte <= 8'h3C;
        regReadData <= 32'h8000_0001;
        frame(48'hA2, 8);
        check_val("short status", 48'h3C, rx);
        check_num("invalid", 1, badCount);
        check_num("short writes", 2, wrCount);
        frame(48'h21_0000_0000, 40);
        check_val("reply kept", 48'h3C_0012_3456, rx);
        $display("test_short done");
    endtask

    task automatic test_long();
        frame(48'h5A_A2CA_FEF0_0D, 48);
        check_val("chained", 48'h3C_8000_0001_5A, rx);
        check_val("last forty", 48'hCAFE_F00D, regWriteData);
        check_num("long writes", 3, wrCount);
        $display("test_long done");
    endtask

    // Legal traffic so far must not have raised the speed flag; the glitch must raise it once.
    task automatic test_fast();
        sras_host_model_inst.glitch();
        check_num("too fast", 1, fastCount);
        check_num("glitch invalid", 2, badCount);
        check_num("glitch writes", 3, wrCount);
        check_val("glitch addr", 48'h22, regAddr);
        $display("test_fast done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end

    initial begin
        rst_b = 1'h0;
        statusByte = 8'h00;
        regReadData = 32'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'h1;
        repeat (4) @(posedge clock);
        test_pipeline();
        test_short();
        test_long();
        test_fast();
        print_verdict();
    end

    // Eight frames need under 50 us; four times that is ample.
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule
